/* lpinit_ctrl.sv */
// Initialization state block of a low-power DRAM, fed by the link-side command decoder
`default_nettype none
// Summary of operation
// - Outputs stay high-impedance whenever sampled clock-enable is low.
// - During auto-initialization only mode reads and power-down commands accepted; the code also accepts NOP.
// - Auto-initialization finishes within 10 us of the reset write.
// - Clearing the pending flag puts the memory in idle.
// - Ready for normal operation no sooner than 1 us after calibration.
// - After full initialization any valid command is accepted.
// - A reset write at any time restarts initialization at the reset step.
// - Bit 0 of info register: 1 pending, 0 complete.
// - Mode registers use mode-register read and write commands.
module lpinit_ctrl
    import lpinit_pkg::*;
(
    // System clock and control
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // Link side
    input wire logic link_clk_i,
    input wire logic cke_i,
    input wire logic cmd_toggle_i,
    input wire lpi_req_t cmd_i,
    // Status
    output logic out_hiz_o,
    output logic [7:0] info_reg_o,
    output logic auto_init_pending_flag_o,
    output logic ready_o,
    output logic cmd_accept_o,
    output logic cmd_reject_o,
    output logic timeout_o
);
    // Link-side capture of clock-enable, read only by the synchroniser below
    logic cke_link;
    always_ff @(posedge link_clk_i) begin
        cke_link <= cke_i;
    end

    // Level and event crossings into the system domain
    logic cke_s1, cke_s2, tog_s1, tog_s2, tog_s3;
    lpi_req_t req_s1, req_s2;
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            cke_s1 <= 1'b0;
            cke_s2 <= 1'b0;
            tog_s1 <= 1'b0;
            tog_s2 <= 1'b0;
            tog_s3 <= 1'b0;
            req_s1 <= '0;
            req_s2 <= '0;
        end else if (ce_i) begin
            cke_s1 <= cke_link;
            cke_s2 <= cke_s1;
            tog_s1 <= cmd_toggle_i;
            tog_s2 <= tog_s1;
            tog_s3 <= tog_s2;
            req_s1 <= cmd_i;
            req_s2 <= req_s1;
        end
    end
    // Command word is held stable by the sender across its toggle
    logic cmd_evt;
    assign cmd_evt = ce_i && (tog_s2 ^ tog_s3) && req_s2.valid;

    function automatic logic is_mrw_to(input lpi_req_t r, input logic [7:0] ma);
        is_mrw_to = (r.cmd == LPI_CMD_MRW) && (r.addr == ma);
    endfunction : is_mrw_to

    lpi_state_t state, next_state;
    logic [CNT_W-1:0] cnt, next_cnt, age, next_age;
    logic pend, next_pend, tmo, next_tmo, acc, next_acc, rej, next_rej;

    always_comb begin
        next_state = state;
        next_cnt = cnt;
        next_age = age;
        next_pend = pend;
        next_tmo = tmo;
        // Answer pulses hold their value while the clock enable is low
        next_acc = ce_i ? 1'b0 : acc;
        next_rej = ce_i ? 1'b0 : rej;
        if (ce_i) begin
            if (state == LPI_AUTO_INIT) begin
                next_age = age + 1'b1;
            end
            case (state)
                LPI_POWERUP: ;
                LPI_AUTO_INIT: begin
                    if (cnt != '0) begin
                        next_cnt = cnt - 1'b1;
                    end else begin
                        next_pend = 1'b0;
                        next_state = LPI_READY;
                    end
                    if (age >= CNT_W'(AUTO_INIT_MAX_CYC) && pend) begin
                        next_tmo = 1'b1;
                    end
                end
                LPI_ZQ_CAL: begin
                    if (cnt != '0) begin
                        next_cnt = cnt - 1'b1;
                    end else begin
                        next_state = LPI_READY;
                    end
                end
                LPI_READY: ;
                default: next_state = LPI_POWERUP;
            endcase
            if (cmd_evt) begin
                if (is_mrw_to(req_s2, MA_RESET)) begin
                    next_state = LPI_AUTO_INIT;
                    next_cnt = CNT_W'(AUTO_INIT_BUSY_CYC);
                    next_age = '0;
                    next_pend = 1'b1;
                    next_tmo = 1'b0;
                    next_acc = 1'b1;
                end else if (state == LPI_AUTO_INIT) begin
                    if (req_s2.cmd inside {LPI_CMD_MRR, LPI_CMD_PDE, LPI_CMD_PDX,
                                           LPI_CMD_NOP}) begin
                        next_acc = 1'b1;
                    end else begin
                        next_rej = 1'b1;
                    end
                end else if (state == LPI_READY && is_mrw_to(req_s2, MA_IO_CAL)) begin
                    next_state = LPI_ZQ_CAL;
                    next_cnt = CNT_W'(ZQ_CAL_CYC);
                    next_acc = 1'b1;
                end else if (state == LPI_READY || req_s2.cmd == LPI_CMD_MRW
                             || req_s2.cmd == LPI_CMD_NOP) begin
                    next_acc = 1'b1;
                end else begin
                    next_rej = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            state <= LPI_POWERUP;
            cnt <= '0;
            age <= '0;
            pend <= 1'b1;
            tmo <= 1'b0;
            acc <= 1'b0;
            rej <= 1'b0;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            age <= next_age;
            pend <= next_pend;
            tmo <= next_tmo;
            acc <= next_acc;
            rej <= next_rej;
        end
    end

    assign out_hiz_o = !cke_s2;
    assign info_reg_o = {7'h00, pend};
    assign auto_init_pending_flag_o = pend;
    assign ready_o = (state == LPI_READY) && !pend;
    assign cmd_accept_o = acc;
    assign cmd_reject_o = rej;
    assign timeout_o = tmo;

    // Rule checks on the registered state and the answer pulses
    a_hiz_cke: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        ce_i && !cke_s1 |=> out_hiz_o)
        else $error("outputs driven while cke low");
    a_reset_sets: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        cmd_evt && is_mrw_to(req_s2, MA_RESET) |=> pend && state == LPI_AUTO_INIT)
        else $error("reset write did not restart init");
    a_init_bound: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        state == LPI_AUTO_INIT |-> age <= CNT_W'(AUTO_INIT_MAX_CYC))
        else $error("auto init exceeded maximum");
    a_idle_clear: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        $fell(pend) |-> state == LPI_READY)
        else $error("flag cleared without idle");
    a_flag_bit: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        info_reg_o[AUTO_INIT_BIT] == (state == LPI_AUTO_INIT || state == LPI_POWERUP && pend))
        else $error("info bit mismatch");
    a_reject_init: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        cmd_evt && state == LPI_AUTO_INIT && req_s2.cmd == LPI_CMD_OTHER |=> rej)
        else $error("command accepted during auto init");
    a_init_mrw: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        cmd_evt && state == LPI_AUTO_INIT && req_s2.cmd == LPI_CMD_MRW
            && !is_mrw_to(req_s2, MA_RESET) |=> rej)
        else $error("write accepted during auto init");
    a_zq_start: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        cmd_evt && state == LPI_READY && is_mrw_to(req_s2, MA_IO_CAL) |=> state == LPI_ZQ_CAL)
        else $error("calibration write did not start calibration");
    a_zq_min: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        $rose(state == LPI_ZQ_CAL) |-> !ready_o [*8])
        else $error("ready too soon");
    a_ready_accept: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        cmd_evt && ready_o && req_s2.cmd == LPI_CMD_OTHER |=> acc)
        else $error("valid command refused when ready");
    a_pend_rise: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        $rose(pend) |-> state == LPI_AUTO_INIT)
        else $error("pending flag set outside auto init");
    c_reset_cmd: cover property (@(posedge ref_clk_i) cmd_evt && is_mrw_to(req_s2, MA_RESET));
    c_init_done: cover property (@(posedge ref_clk_i) $fell(pend));
    c_zq_start: cover property (@(posedge ref_clk_i) $rose(state == LPI_ZQ_CAL));
    c_zq_done: cover property (@(posedge ref_clk_i) $fell(state == LPI_ZQ_CAL));
    c_ce_hold: cover property (@(posedge ref_clk_i) !ce_i && state == LPI_AUTO_INIT);
endmodule : lpinit_ctrl
`default_nettype wire

/* lpinit_ctrl_tb_top.sv */
// Self-checking bench of the initialization state block
`default_nettype none
module lpinit_ctrl_tb_top
    import lpinit_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic ref_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic ce_i = 1'b1;
    wire logic link_clk;
    wire logic cke;
    wire logic cmd_toggle;
    lpi_req_t cmd;
    logic out_hiz_o, auto_init_pending_flag_o, ready_o, cmd_accept_o, cmd_reject_o, timeout_o;
    logic [7:0] info_reg_o;
    int errors = 0;
    int samples_checked = 0;
    lpi_cmd_t kinds[4] = '{LPI_CMD_MRR, LPI_CMD_PDE, LPI_CMD_PDX, LPI_CMD_OTHER};
    always #20 ref_clk_i = ~ref_clk_i;
    lpinit_host_model host (.ref_clk_i(ref_clk_i), .link_clk_o(link_clk), .cke_o(cke),
        .cmd_toggle_o(cmd_toggle), .cmd_o(cmd));
    lpinit_ctrl dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .ce_i(ce_i), .link_clk_i(link_clk),
        .cke_i(cke), .cmd_toggle_i(cmd_toggle), .cmd_i(cmd), .out_hiz_o(out_hiz_o),
        .info_reg_o(info_reg_o), .auto_init_pending_flag_o(auto_init_pending_flag_o),
        .ready_o(ready_o), .cmd_accept_o(cmd_accept_o), .cmd_reject_o(cmd_reject_o),
        .timeout_o(timeout_o));
    task automatic end_sim();
        if (errors == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : end_sim
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk_i);
        #1;
    endtask : tick
    task automatic give_up();
        errors++;
        end_sim();
    endtask : give_up
    // Issues one command and checks which answer pulse comes back
    task automatic send(input lpi_cmd_t kind, input logic [7:0] addr, input logic exp_acc);
        int i;
        host.issue(kind, addr);
        for (i = 0; i < 10 && cmd_accept_o !== 1'b1 && cmd_reject_o !== 1'b1; i++) tick(1);
        if (i == 10) give_up();
        check({7'h00, cmd_accept_o}, {7'h00, exp_acc});
        check({7'h00, cmd_reject_o}, {7'h00, ~exp_acc});
    endtask : send
    task automatic wait_ready(input int bound, output int n);
        for (n = 0; n < bound && ready_o !== 1'b1; n++) tick(1);
        if (n == bound) give_up();
    endtask : wait_ready
    initial begin
        int n;
        repeat (16) @(posedge ref_clk_i);
        #1 rst_i = 1'b0;
        check({7'h00, out_hiz_o}, 8'h01);
        check(info_reg_o, 8'h01);
        check({7'h00, ready_o}, 8'h00);
        host.set_cke(1'b1);
        tick(4);
        check({7'h00, out_hiz_o}, 8'h00);
        send(LPI_CMD_MRR, MA_INFO, 1'b0);
        send(LPI_CMD_MRW, MA_RESET, 1'b1);
        check({7'h00, auto_init_pending_flag_o}, 8'h01);
        foreach (kinds[k]) send(kinds[k], MA_INFO, logic'(k < 3));
        send(LPI_CMD_MRW, 8'h01, 1'b0);
        // Clock enable low freezes the busy count: the flag must outlast the busy time
        ce_i = 1'b0;
        tick(AUTO_INIT_BUSY_CYC + 10);
        check({7'h00, auto_init_pending_flag_o}, 8'h01);
        check({7'h00, ready_o}, 8'h00);
        ce_i = 1'b1;
        wait_ready(AUTO_INIT_MAX_CYC, n);
        check(info_reg_o, 8'h00);
        check({7'h00, timeout_o}, 8'h00);
        send(LPI_CMD_MRW, MA_IO_CAL, 1'b1);
        tick(1);
        check({7'h00, ready_o}, 8'h00);
        wait_ready(ZQ_CAL_CYC + 10, n);
        check({7'h00, logic'(n >= ZQ_CAL_CYC - 4)}, 8'h01);
        send(LPI_CMD_OTHER, 8'h01, 1'b1);
        for (int m = 1; m <= 3; m++) send(LPI_CMD_MRW, 8'(m), 1'b1);
        send(LPI_CMD_MRW, MA_RESET, 1'b1);
        check({7'h00, auto_init_pending_flag_o}, 8'h01);
        check({7'h00, ready_o}, 8'h00);
        host.set_cke(1'b0);
        tick(4);
        check({7'h00, out_hiz_o}, 8'h01);
        end_sim();
    end
endmodule : lpinit_ctrl_tb_top
`default_nettype wire

/* lpinit_host_model.sv */
// Controller-side model: link clock, clock-enable level and toggled commands
`default_nettype none
module lpinit_host_model
    import lpinit_pkg::*;
(
    // Reference clock
    input wire logic ref_clk_i,
    // Link side
    output logic link_clk_o,
    output logic cke_o,
    output logic cmd_toggle_o,
    output lpi_req_t cmd_o
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        link_clk_o = 1'b0;
        cke_o = 1'b0;
        cmd_toggle_o = 1'b0;
        cmd_o = '{valid: 1'b0, cmd: LPI_CMD_NOP, addr: 8'h00, data: 8'h00};
        #3.3;
        forever #7.5 link_clk_o = ~link_clk_o;
    end
    task automatic set_cke(input logic level);
        @(posedge ref_clk_i);
        #1 cke_o = level;
    endtask : set_cke
    // Command is settled one cycle before the toggle and held until the next one
    task automatic issue(input lpi_cmd_t kind, input logic [7:0] addr);
        @(posedge ref_clk_i);
        #1 cmd_o = '{valid: 1'b1, cmd: kind, addr: addr, data: 8'h00};
        @(posedge ref_clk_i);
        #1 cmd_toggle_o = ~cmd_toggle_o;
    endtask : issue
endmodule : lpinit_host_model
`default_nettype wire

/* lpinit_pkg.sv */
// Package for the low-power DRAM initialization-state block
`default_nettype none
package lpinit_pkg;
    localparam int REF_CLK_NS = 40;
    localparam int AUTO_INIT_MAX_US = 10;
    localparam int AUTO_INIT_BUSY_NS = 2000;
    localparam int IMPEDANCE_CAL_INIT_NS = 1000;
    localparam int AUTO_INIT_BUSY_CYC = (AUTO_INIT_BUSY_NS + REF_CLK_NS - 1) / REF_CLK_NS;
    localparam int AUTO_INIT_MAX_CYC = (AUTO_INIT_MAX_US * 1000) / REF_CLK_NS;
    localparam int ZQ_CAL_CYC = (IMPEDANCE_CAL_INIT_NS + REF_CLK_NS - 1) / REF_CLK_NS;
    localparam int CNT_W = 16;
    localparam logic [7:0] MA_INFO = 8'h00;
    localparam logic [7:0] MA_IO_CAL = 8'h0a;
    localparam logic [7:0] MA_RESET = 8'h3f;
    localparam int AUTO_INIT_BIT = 0;
    typedef enum logic [2:0] {
        LPI_CMD_NOP, LPI_CMD_MRW, LPI_CMD_MRR, LPI_CMD_PDE, LPI_CMD_PDX, LPI_CMD_OTHER
    } lpi_cmd_t;
    typedef struct packed {
        logic valid;
        lpi_cmd_t cmd;
        logic [7:0] addr;
        logic [7:0] data;
    } lpi_req_t;
    typedef enum logic [1:0] {
        LPI_POWERUP, LPI_AUTO_INIT, LPI_ZQ_CAL, LPI_READY
    } lpi_state_t;
endpackage : lpinit_pkg
`default_nettype wire
